//--- src/eerc_pkg.sv
// package: register map, field layout, reset values and timing counts for the enable output block
package eerc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_SRC_SEL   = 8'h17;
    localparam logic [7:0] ADDR_DELAY     = 8'h18;
    localparam logic [7:0] ADDR_BUCK_SST  = 8'h19;
    localparam logic [7:0] ADDR_LIN_SST   = 8'h1a;
    localparam logic [7:0] ADDR_B1_CFG    = 8'h1b;
    localparam logic [7:0] ADDR_SLOT2     = 8'h15;
    // reset values
    localparam logic [7:0] RST_SRC_SEL    = 8'hc0;
    localparam logic [7:0] RST_DELAY      = 8'h00;
    localparam logic [7:0] RST_BUCK_SST   = 8'h55;
    localparam logic [7:0] RST_LIN_SST    = 8'h00;
    localparam logic [7:0] RST_B1_CFG     = 8'h6a;
    localparam logic [7:0] RST_SLOT2      = 8'h07;
    // writable bit masks (reserved bits read zero)
    localparam logic [7:0] MASK_SRC_SEL   = 8'hfe;
    localparam logic [7:0] MASK_LIN_SST   = 8'hc0;
    localparam logic [7:0] MASK_B1_CFG    = 8'hfe;
    localparam logic [7:0] MASK_SLOT2     = 8'h1f;
    // field positions
    localparam int SRC_MSB  = 7;
    localparam int SRC_LSB  = 6;
    localparam int RAIL_MSB = 5;
    localparam int RAIL_LSB = 3;
    localparam int PIN_MSB  = 2;
    localparam int PIN_LSB  = 1;
    localparam int D1_MSB   = 7;
    localparam int D1_LSB   = 4;
    localparam int D2_MSB   = 3;
    localparam int D2_LSB   = 0;
    localparam int LIN_MSB  = 7;
    localparam int LIN_LSB  = 6;
    localparam int ILIM_MSB = 7;
    localparam int ILIM_LSB = 6;
    localparam int SLEW_MSB = 5;
    localparam int SLEW_LSB = 4;
    localparam int FREQ_MSB = 3;
    localparam int FREQ_LSB = 1;
    localparam int SLOT_MSB = 4;
    localparam int SLOT_LSB = 0;
    // source codes
    typedef enum logic [1:0]
    {
        EERC_SRC_RAIL  = 2'h0,
        EERC_SRC_PIN   = 2'h1,
        EERC_SRC_SOFT  = 2'h2,
        EERC_SRC_SLOT  = 2'h3
    } eerc_src_e;
    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int DELAY_STEP_US  = 250;
    localparam int SLOT_STEP_US   = 250;
    localparam int DELAY_STEP_CYC = DELAY_STEP_US * 1000 / CLK_PERIOD_NS;
    localparam int SLOT_STEP_CYC  = SLOT_STEP_US * 1000 / CLK_PERIOD_NS;
endpackage

//--- src/eerc_tick_if.sv
// interface: step tick carried from the prescaler to the enable output logic
`timescale 1ns/1ps
interface eerc_tick_if;
    logic tick;
    logic clear;
    modport src (output tick, input clear);
    modport dst (input tick, output clear);
endinterface

//--- src/eerc_step_timer.sv
// module: prescaler giving one tick per fixed number of clock cycles
`timescale 1ns/1ps
module eerc_step_timer #(
    parameter int STEP_CYC = 25000
) (
    input  wire logic   i_sys_clk,
    input  wire logic   i_reset,
    eerc_tick_if.src    tk
);
    localparam int CW = $clog2(STEP_CYC);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_r;
    logic          tick_nxt;

    // refuse step counts the wrap compare cannot serve
    if (STEP_CYC < 2)
    begin
        $error("step count too small");
    end

    always_comb
    begin
        tick_nxt = 1'b0;
        cnt_nxt  = cnt_r + 1'b1;
        if (tk.clear)
            cnt_nxt = '0;
        else if (cnt_r == CW'(STEP_CYC - 1))
        begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.tick = tick_r;
endmodule

//--- src/eerc_top.sv
// module: second external enable output generator and rail configuration registers
`timescale 1ns/1ps
//
// Operation
// R1 - Bits 7:6 of the source register choose rail good, input pin, software output or wake slot as the source.
// R2 - With rail sourcing, bits 5:3 pick one of buck1-4, linear 1-2, reset output status or supply monitor.
// R3 - With pin sourcing, bits 2:1 pick general pins 5 to 8 and the output rises after that pin is high.
// R4 - For rail, pin and slot sources the output rises only after the programmed delay has elapsed.
// R5 - The delay register holds output one delay in 7:4 and output two delay in 3:0, each code times 0.25ms.
// R6 - Buck1 to buck3 ramp selects encode 125, 250, 500 and 750 us.
// R7 - Buck4 ramp select uses the buck encoding in buck mode and 250 or 500 us in linear mode.
// R8 - Linear 1 and 2 ramp selects at bits 7 and 6 mean 250 us clear and 500 us set; other bits read zero.
// R9 - Buck1 current limit code in bits 7:6 gives 4, 5, 6 or 7 A with 5 A as default.
// R10 - Buck1 slew code in bits 5:4 gives 20, 15, 10 or 5 mV/us upward, always 5 downward, default 10.
// R11 - Buck1 frequency code in bits 3:1 gives 1, 1, 1, 1, 1.5, 2, 2.5 or 3 MHz with 2 MHz default.
// R12 - In slot mode the slot code zero disables, code 1 is 0 us and each further code adds 250 us.
// R13 - The output stays low while the source is low or the delay runs; reserved bits read zero.
module eerc_top #(
    parameter int DELAY_STEP_CYC = eerc_pkg::DELAY_STEP_CYC,
    parameter int SLOT_STEP_CYC  = eerc_pkg::SLOT_STEP_CYC
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic [7:0]       o_reg_rdata,
    input  wire logic [7:0]  i_rail_power_good,
    input  wire logic [3:0]  i_gpio_high,
    input  wire logic        i_soft_out_level,
    input  wire logic        i_wake_start,
    output logic             o_second_enable_output,
    output logic [7:0]       o_buck_soft_start,
    output logic [1:0]       o_linear_soft_start,
    output logic [1:0]       o_buck1_current_limit,
    output logic [1:0]       o_buck1_slew_select,
    output logic [2:0]       o_buck1_switch_frequency,
    output logic [3:0]       o_out1_delay_code
);
    // *************************************
    // registers
    // *************************************
    logic [7:0] src_r, src_nxt;
    logic [7:0] dly_r, dly_nxt;
    logic [7:0] bsst_r, bsst_nxt;
    logic [7:0] lsst_r, lsst_nxt;
    logic [7:0] b1_r, b1_nxt;
    logic [7:0] slot_r, slot_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    always_comb
    begin
        src_nxt   = src_r;
        dly_nxt   = dly_r;
        bsst_nxt  = bsst_r;
        lsst_nxt  = lsst_r;
        b1_nxt    = b1_r;
        slot_nxt  = slot_r;
        rdata_nxt = rdata_r;
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                eerc_pkg::ADDR_SRC_SEL:  src_nxt  = i_reg_wdata & eerc_pkg::MASK_SRC_SEL;  // [R1] [R13]
                eerc_pkg::ADDR_DELAY:    dly_nxt  = i_reg_wdata;                           // [R5]
                eerc_pkg::ADDR_BUCK_SST: bsst_nxt = i_reg_wdata;                           // [R6] [R7]
                eerc_pkg::ADDR_LIN_SST:  lsst_nxt = i_reg_wdata & eerc_pkg::MASK_LIN_SST;  // [R8] [R13]
                eerc_pkg::ADDR_B1_CFG:   b1_nxt   = i_reg_wdata & eerc_pkg::MASK_B1_CFG;   // [R9] [R10] [R11]
                eerc_pkg::ADDR_SLOT2:    slot_nxt = i_reg_wdata & eerc_pkg::MASK_SLOT2;    // [R12]
                default:                 ;
            endcase
        end
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                eerc_pkg::ADDR_SRC_SEL:  rdata_nxt = src_r;
                eerc_pkg::ADDR_DELAY:    rdata_nxt = dly_r;
                eerc_pkg::ADDR_BUCK_SST: rdata_nxt = bsst_r;
                eerc_pkg::ADDR_LIN_SST:  rdata_nxt = lsst_r;
                eerc_pkg::ADDR_B1_CFG:   rdata_nxt = b1_r;
                eerc_pkg::ADDR_SLOT2:    rdata_nxt = slot_r;
                default:                 rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            src_r   <= eerc_pkg::RST_SRC_SEL;
            dly_r   <= eerc_pkg::RST_DELAY;
            bsst_r  <= eerc_pkg::RST_BUCK_SST;
            lsst_r  <= eerc_pkg::RST_LIN_SST;
            b1_r    <= eerc_pkg::RST_B1_CFG;
            slot_r  <= eerc_pkg::RST_SLOT2;
            rdata_r <= 8'h00;
        end
        else
        begin
            src_r   <= src_nxt;
            dly_r   <= dly_nxt;
            bsst_r  <= bsst_nxt;
            lsst_r  <= lsst_nxt;
            b1_r    <= b1_nxt;
            slot_r  <= slot_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // *************************************
    // source selection
    // *************************************
    eerc_pkg::eerc_src_e src_sel;
    logic [2:0]          rail_sel;
    logic [1:0]          pin_sel;
    logic                src_level;

    assign src_sel  = eerc_pkg::eerc_src_e'(src_r[eerc_pkg::SRC_MSB:eerc_pkg::SRC_LSB]);   // [R1]
    assign rail_sel = src_r[eerc_pkg::RAIL_MSB:eerc_pkg::RAIL_LSB];                        // [R2]
    assign pin_sel  = src_r[eerc_pkg::PIN_MSB:eerc_pkg::PIN_LSB];                          // [R3]

    // *************************************
    // step tick sources
    // *************************************
    eerc_tick_if dtk ();
    eerc_tick_if stk ();

    eerc_step_timer #(.STEP_CYC(DELAY_STEP_CYC)) u_dly_tick
    (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .tk        (dtk.src)
    );

    eerc_step_timer #(.STEP_CYC(SLOT_STEP_CYC)) u_slot_tick
    (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .tk        (stk.src)
    );

    // *************************************
    // wake slot: source rises at the chosen slot after wake start
    // *************************************
    logic       wake_run_r, wake_run_nxt;
    logic [4:0] slot_cnt_r, slot_cnt_nxt;
    logic       slot_hit_r, slot_hit_nxt;

    assign stk.clear = i_wake_start;

    always_comb
    begin
        wake_run_nxt = wake_run_r;
        slot_cnt_nxt = slot_cnt_r;
        slot_hit_nxt = slot_hit_r;
        if (i_wake_start)
        begin
            wake_run_nxt = 1'b1;
            slot_cnt_nxt = 5'h01;
            slot_hit_nxt = 1'b0;
        end
        else if (wake_run_r)
        begin
            if (slot_r[eerc_pkg::SLOT_MSB:eerc_pkg::SLOT_LSB] == 5'h00)
                wake_run_nxt = 1'b0;                             // [R12]
            else if (slot_cnt_r == slot_r[eerc_pkg::SLOT_MSB:eerc_pkg::SLOT_LSB])
            begin
                slot_hit_nxt = 1'b1;                             // [R12]
                wake_run_nxt = 1'b0;
            end
            else if (stk.tick)
                slot_cnt_nxt = slot_cnt_r + 5'h01;               // [R12]
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            wake_run_r <= 1'b0;
            slot_cnt_r <= 5'h00;
            slot_hit_r <= 1'b0;
        end
        else
        begin
            wake_run_r <= wake_run_nxt;
            slot_cnt_r <= slot_cnt_nxt;
            slot_hit_r <= slot_hit_nxt;
        end
    end

    always_comb
    begin
        case (src_sel)
            eerc_pkg::EERC_SRC_RAIL: src_level = i_rail_power_good[rail_sel];   // [R2]
            eerc_pkg::EERC_SRC_PIN:  src_level = i_gpio_high[pin_sel];          // [R3]
            eerc_pkg::EERC_SRC_SOFT: src_level = i_soft_out_level;
            eerc_pkg::EERC_SRC_SLOT: src_level = slot_hit_r;
            default:                 src_level = 1'b0;
        endcase
    end

    // *************************************
    // output delay state machine
    // *************************************
    typedef enum logic [2:0]
    {
        EERC_IDLE = 3'b001,
        EERC_WAIT = 3'b010,
        EERC_ON   = 3'b100
    } eerc_state_e;

    eerc_state_e state_r, state_nxt;
    logic [3:0]  dcnt_r, dcnt_nxt;
    logic        out_r, out_nxt;
    logic [3:0]  dcode;

    assign dcode     = dly_r[eerc_pkg::D2_MSB:eerc_pkg::D2_LSB];                    // [R5]
    assign dtk.clear = (state_r == EERC_IDLE);

    always_comb
    begin
        state_nxt = state_r;
        dcnt_nxt  = dcnt_r;
        out_nxt   = 1'b0;
        case (state_r)
            EERC_IDLE:
            begin
                dcnt_nxt = 4'h0;
                if (src_level && (src_sel == eerc_pkg::EERC_SRC_SOFT || dcode == 4'h0))
                begin
                    state_nxt = EERC_ON;
                    out_nxt   = 1'b1;
                end
                else if (src_level)
                    state_nxt = EERC_WAIT;                                          // [R4]
            end
            EERC_WAIT:
            begin
                if (!src_level)
                    state_nxt = EERC_IDLE;                                          // [R13]
                else if (src_sel == eerc_pkg::EERC_SRC_SOFT || (dtk.tick && (dcnt_r + 4'h1 >= dcode)))
                begin
                    state_nxt = EERC_ON;                                            // [R4]
                    out_nxt   = 1'b1;
                end
                else if (dtk.tick)
                    dcnt_nxt = dcnt_r + 4'h1;
            end
            EERC_ON:
            begin
                if (!src_level)
                    state_nxt = EERC_IDLE;                                          // [R13]
                else
                    out_nxt = 1'b1;
            end
            default:
                state_nxt = EERC_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            state_r <= EERC_IDLE;
            dcnt_r  <= 4'h0;
            out_r   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            dcnt_r  <= dcnt_nxt;
            out_r   <= out_nxt;
        end
    end

    assign o_reg_rdata              = rdata_r;
    assign o_second_enable_output   = out_r;
    assign o_buck_soft_start        = bsst_r;                                       // [R6] [R7]
    assign o_linear_soft_start      = lsst_r[eerc_pkg::LIN_MSB:eerc_pkg::LIN_LSB];  // [R8]
    assign o_buck1_current_limit    = b1_r[eerc_pkg::ILIM_MSB:eerc_pkg::ILIM_LSB];  // [R9]
    assign o_buck1_slew_select      = b1_r[eerc_pkg::SLEW_MSB:eerc_pkg::SLEW_LSB];  // [R10]
    assign o_buck1_switch_frequency = b1_r[eerc_pkg::FREQ_MSB:eerc_pkg::FREQ_LSB];  // [R11]
    assign o_out1_delay_code        = dly_r[eerc_pkg::D1_MSB:eerc_pkg::D1_LSB];
endmodule

//--- verification/eerc_top_assertions.sv
// checker: port-level properties of the enable output and configuration block
`timescale 1ns/1ps
module eerc_top_assertions #(
    parameter int DELAY_STEP_CYC = 4,
    parameter int SLOT_STEP_CYC  = 4
) (
    input wire logic       i_sys_clk,
    input wire logic       i_reset,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [7:0] i_rail_power_good,
    input wire logic [3:0] i_gpio_high,
    input wire logic       i_soft_out_level,
    input wire logic       i_wake_start,
    input wire logic       o_second_enable_output,
    input wire logic [7:0] o_buck_soft_start,
    input wire logic [1:0] o_linear_soft_start,
    input wire logic [1:0] o_buck1_current_limit,
    input wire logic [1:0] o_buck1_slew_select,
    input wire logic [2:0] o_buck1_switch_frequency,
    input wire logic [3:0] o_out1_delay_code
);
    // *****
    // shadow of source and delay fields, run length of the selected source
    // *****
    logic [7:0]  src_r, src_nxt;
    logic [3:0]  dly_r, dly_nxt;
    logic [15:0] hi_r, hi_nxt;
    logic        sel_hi;
    always_comb
    begin
        src_nxt = (i_reg_wr && i_reg_addr == 8'h17) ? (i_reg_wdata & 8'hfe) : src_r;
        dly_nxt = (i_reg_wr && i_reg_addr == 8'h18) ? i_reg_wdata[3:0] : dly_r;
        sel_hi  = src_r[6] ? i_gpio_high[src_r[2:1]] : i_rail_power_good[src_r[5:3]];
        hi_nxt  = (sel_hi && !i_reg_wr) ? ((hi_r == 16'hffff) ? hi_r : hi_r + 16'h1) : 16'h0;
    end
    always_ff @(posedge i_sys_clk)
    begin
        src_r <= i_reset ? 8'hc0 : src_nxt;
        dly_r <= i_reset ? 4'h0 : dly_nxt;
        hi_r  <= i_reset ? 16'h0 : hi_nxt;
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    a_soft_follow: assert property (src_r[7:6] == 2'h2 && !i_reg_wr
        |=> o_second_enable_output == $past(i_soft_out_level)) else $error("soft source not followed");
    a_read_source: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h17
        |=> o_reg_rdata == src_r) else $error("source register readback wrong");
    a_rise_delay: assert property ($rose(o_second_enable_output) && !src_r[7]
        |-> hi_r >= dly_r * DELAY_STEP_CYC) else $error("output rose before delay");
    a_drop_low: assert property (!src_r[7] && !sel_hi && !i_reg_wr
        |=> !o_second_enable_output) else $error("output high with source low");
    a_unmapped_zero: assert property (i_reg_rd && !(i_reg_addr inside {8'h15, [8'h17:8'h1b]})
        |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_cfg_fields: assert property (i_reg_wr && i_reg_addr == 8'h1b
        |=> {o_buck1_current_limit, o_buck1_slew_select, o_buck1_switch_frequency} == $past(i_reg_wdata[7:1]))
        else $error("buck1 fields not updated");
    a_ramp_write: assert property (i_reg_wr && i_reg_addr == 8'h19
        |=> o_buck_soft_start == $past(i_reg_wdata)) else $error("ramp selects not updated");
    a_linear_write: assert property (i_reg_wr && i_reg_addr == 8'h1a
        |=> o_linear_soft_start == $past(i_reg_wdata[7:6])) else $error("linear ramp not updated");
    c_rise: cover property ($rose(o_second_enable_output) && dly_r != 4'h0);
    c_slot: cover property (src_r[7:6] == 2'h3 && $rose(o_second_enable_output));
    c_pin: cover property (src_r[7:6] == 2'h1 && $rose(o_second_enable_output));
endmodule
bind eerc_top eerc_top_assertions #(.DELAY_STEP_CYC(DELAY_STEP_CYC), .SLOT_STEP_CYC(SLOT_STEP_CYC)) chk (.*);

//--- verification/eerc_load_model.sv
// partner: load switch that reports good after its enable has stood high a while
`timescale 1ns/1ps
module eerc_load_model #(
    parameter int SETTLE = 3
) (
    input  wire logic i_sys_clk,
    input  wire logic i_enable,
    output logic      o_load_good
);
    int cnt = 0;
    always @(posedge i_sys_clk)
    begin
        cnt = i_enable ? cnt + 1 : 0;
        o_load_good <= (cnt >= SETTLE);
    end
endmodule

//--- verification/eerc_top_tb.sv
// testbench: register access, enable output sources and delays
`timescale 1ns/1ps
module eerc_top_tb;
    localparam int STEP = 4;
    logic       i_sys_clk = 1'b0;
    logic       i_reset = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic       i_reg_wr = 1'b0;
    logic       i_reg_rd = 1'b0;
    logic [7:0] i_rail_power_good = 8'h00;
    logic [3:0] i_gpio_high = 4'h0;
    logic       i_soft_out_level = 1'b0;
    logic       i_wake_start = 1'b0;
    logic [7:0] o_reg_rdata, o_buck_soft_start;
    logic [3:0] o_out1_delay_code;
    logic [2:0] o_buck1_switch_frequency;
    logic [1:0] o_linear_soft_start, o_buck1_current_limit, o_buck1_slew_select;
    logic       o_second_enable_output, load_good;
    int         num_errors = 0;
    int         total_checks = 0;
    int         cyc = 0;
    eerc_top #(.DELAY_STEP_CYC(STEP), .SLOT_STEP_CYC(STEP)) uut (.*);
    eerc_load_model load (.i_sys_clk(i_sys_clk), .i_enable(o_second_enable_output), .o_load_good(load_good));
    always #5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    // *****
    // comparisons and bus cycles
    // *****
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_sys_clk);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_sys_clk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_sys_clk);
        i_reg_rd = 1'b0;
        @(negedge i_sys_clk);
        check8(o_reg_rdata, exp);
    endtask
    task automatic out_is(input logic v, input int waits);
        repeat (waits) @(negedge i_sys_clk);
        check8({7'h0, o_second_enable_output}, {7'h0, v});
    endtask
    task automatic meas(input int lo, input int hi);
        int n;
        n = 0;
        do
        begin
            @(negedge i_sys_clk);
            n++;
        end
        while (o_second_enable_output !== 1'b1 && n < 200);
        check_rng(n, lo, hi);
    endtask
    // *****
    // scenarios
    // *****
    task automatic t_regs();
        rd(8'h15, 8'h07); rd(8'h17, 8'hc0); rd(8'h18, 8'h00); rd(8'h19, 8'h55);
        rd(8'h1a, 8'h00); rd(8'h1b, 8'h6a); rd(8'h20, 8'h00);
        wr(8'h15, 8'hff); wr(8'h17, 8'hff); wr(8'h1a, 8'hff); wr(8'h1b, 8'hff); wr(8'h33, 8'hff);
        rd(8'h15, 8'h1f); rd(8'h17, 8'hfe); rd(8'h1a, 8'hc0); rd(8'h1b, 8'hfe); rd(8'h33, 8'h00);
        wr(8'h19, 8'h1b); wr(8'h1b, 8'h94); wr(8'h18, 8'ha3); wr(8'h1a, 8'h40);
        check8(o_buck_soft_start, 8'h1b);
        check8({o_buck1_current_limit, o_buck1_slew_select, o_buck1_switch_frequency, 1'b0}, 8'h94);
        check8({o_out1_delay_code, 2'h0, o_linear_soft_start}, 8'ha1);
        rd(8'h18, 8'ha3);
    endtask
    task automatic t_rail_pin(input logic pin, input int idx, input int d);
        wr(8'h18, 8'(d));
        wr(8'h17, pin ? {2'h1, 3'h0, 2'(idx), 1'b0} : {2'h0, 3'(idx), 3'h0});
        i_rail_power_good = pin ? 8'hff : ~(8'h01 << idx);
        i_gpio_high = pin ? ~(4'h1 << idx) : 4'hf;
        out_is(1'b0, 8);
        i_rail_power_good = 8'hff;
        i_gpio_high = 4'hf;
        meas((d == 0) ? 1 : d * STEP + 2, d * STEP + 3);
        i_rail_power_good = 8'h00;
        i_gpio_high = 4'h0;
        out_is(1'b0, 2);
    endtask
    task automatic t_restart();
        i_rail_power_good = 8'h01;
        repeat (6) @(negedge i_sys_clk);
        i_rail_power_good = 8'h00;
        @(negedge i_sys_clk);
        i_rail_power_good = 8'h01;
        meas(3 * STEP + 2, 3 * STEP + 3);
        i_rail_power_good = 8'h00;
    endtask
    task automatic t_soft();
        wr(8'h18, 8'h0f);
        wr(8'h17, 8'h80);
        i_soft_out_level = 1'b1;
        meas(1, 1);
        repeat (4) @(negedge i_sys_clk);
        check8({7'h0, load_good}, 8'h01);
        i_soft_out_level = 1'b0;
        out_is(1'b0, 2);
    endtask
    task automatic t_slot(input logic [7:0] k);
        wr(8'h18, 8'h00);
        wr(8'h15, k);
        wr(8'h17, 8'hc0);
        i_wake_start = 1'b1;
        @(negedge i_sys_clk);
        i_wake_start = 1'b0;
        if (k == 8'h00)
            out_is(1'b0, 40);
        else
            meas((k - 1) * STEP, (k - 1) * STEP + 4);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge i_sys_clk);
        i_reset = 1'b0;
        t_regs();
        for (int r = 0; r < 8; r++)
            t_rail_pin(1'b0, r, r % 3);
        for (int p = 0; p < 4; p++)
            t_rail_pin(1'b1, p, p);
        wr(8'h17, 8'h00);
        wr(8'h18, 8'h03);
        t_restart();
        t_soft();
        t_slot(8'h03);
        t_slot(8'h00);
        tally_and_finish();
    end
endmodule
